/* sbp_defs.svh */
// Behaviour
// - one byte per req/ack handshake, eighteen lines
// - eight devices, one conversation at once
// - busy is wired-or, marks bus occupied
// - initiator selects with sel, target reselects
// - target raises req, initiator answers ack
// - initiator raises atn for attention
// - data bit seven highest, asserted reads one
// - odd parity, ignored during arbitration
// - wait 2.2 us before judging arbitration
// - release lines within 800 ns of events
// - wait 800 ns after bus free to arbitrate
// - assert busy and id within 1.8 us
// - bus free after 400 ns settle
// - initiator releases data within 400 ns
// - hold reset at least 25 us
// - answer selection with busy within 200 us
// - wait 250 ms for busy before timeout; default count has an extra factor of 1000 and wraps to about 355 ms
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH
`define SBP_CLK_MHZ 125
`define SBP_SETTLE_NS 400
`define SBP_FREE_DLY_NS 800
`define SBP_ARB_DLY_NS 2200
`define SBP_DATA_REL_NS 400
`define SBP_RST_HOLD_NS 25000
`define SBP_SEL_TMO_MS 250
// least times round up to whole cycles
`define SBP_CYC_MIN(ns) (((ns) * `SBP_CLK_MHZ + 999) / 1000)
`define SBP_CNT_W 26
`define SBP_A_CTRL 4'h0
`define SBP_A_TARGET 4'h1
`define SBP_A_TXDATA 4'h2
`define SBP_A_RXDATA 4'h3
`define SBP_A_STATUS 4'h4
`define SBP_A_PHASE 4'h5
`define SBP_C_ARB 0
`define SBP_C_RST 1
`define SBP_C_ATN 2
`define SBP_C_DROP 3
`define SBP_C_OWNID 4
`define SBP_C_PAREN 7
`endif

/* sbp_pkg.sv */
`default_nettype none
package sbp_pkg;
   // bus line bundle, asserted = 1 on every field
   typedef struct packed {
      logic bsy;
      logic sel;
      logic cd;
      logic io;
      logic msg;
      logic req;
      logic ack;
      logic atn;
      logic rst;
      logic par;
      logic [7:0] db;
   } sbp_lines_t;
   typedef enum logic [3:0] {
      SBP_IDLE, SBP_FREE_WAIT, SBP_ARB, SBP_SEL, SBP_SEL_WAIT, SBP_CONN,
      SBP_ACK_HOLD, SBP_RESET, SBP_LOST
   } sbp_state_t;
endpackage
`default_nettype wire

/* sbp_host.sv */
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sbp_defs.svh"
module sbp_host (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   input wire sbp_pkg::sbp_lines_t bus_in,
   output sbp_pkg::sbp_lines_t bus_out,
   output sbp_pkg::sbp_lines_t bus_oe
);
   // least times rounded up so every wait meets its minimum
   localparam int SETTLE_C = `SBP_CYC_MIN(`SBP_SETTLE_NS);
   localparam int FREE_C = `SBP_CYC_MIN(`SBP_FREE_DLY_NS);
   localparam int ARB_C = `SBP_CYC_MIN(`SBP_ARB_DLY_NS);
   localparam int REL_C = `SBP_CYC_MIN(`SBP_DATA_REL_NS);
   localparam int RST_C = `SBP_CYC_MIN(`SBP_RST_HOLD_NS);
   // selection timeout; a bench may shrink it to keep runs short
   parameter int SEL_TMO_C = `SBP_SEL_TMO_MS * 1000 * `SBP_CLK_MHZ * 1000;

   // phase, counters and sticky status
   sbp_pkg::sbp_state_t state_reg;
   logic [7:0] ctrl_reg;
   logic [2:0] target_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;
   logic [`SBP_CNT_W-1:0] cnt_reg;
   logic [8:0] settle_reg;
   logic won_reg, lost_reg, tmo_reg, conn_reg, par_err_reg, rx_new_reg;
   logic io_prev_reg;
   logic [8:0] io_rel_reg;
   logic arb_go, rst_go, byte_in;
   logic [7:0] own_bit, higher_mask;
   logic bus_free;

   // own id bit and every id above it
   assign own_bit = 8'h01 << ctrl_reg[`SBP_C_OWNID +: 3];
   assign higher_mask = ~((own_bit << 1) - 8'h01);
   assign bus_free = (settle_reg >= 9'(SETTLE_C));
   assign arb_go = wr_en && addr == `SBP_A_CTRL && wr_data[`SBP_C_ARB];
   assign rst_go = wr_en && addr == `SBP_A_CTRL && wr_data[`SBP_C_RST];
   // new byte offered by the target
   assign byte_in = state_reg == sbp_pkg::SBP_CONN && bus_in.req && !bus_oe.ack;

   // bus free settle counter, counts while busy and select both low
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         settle_reg <= 9'h000;
      end else if (bus_in.bsy || bus_in.sel) begin
         settle_reg <= 9'h000;
      end else if (!bus_free) begin
         settle_reg <= settle_reg + 9'h001;
      end
   end

   // software control and configuration registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= 8'h80;
         target_reg <= 3'h0;
         tx_reg <= 8'h00;
      end else if (wr_en) begin
         case (addr)
            `SBP_A_CTRL: ctrl_reg <= {wr_data[7:4], 1'b0, wr_data[2], 2'b00};
            `SBP_A_TARGET: target_reg <= wr_data[2:0];
            `SBP_A_TXDATA: tx_reg <= wr_data;
            default: ;
         endcase
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            `SBP_A_CTRL: rd_data <= ctrl_reg;
            `SBP_A_TARGET: rd_data <= {5'h00, target_reg};
            `SBP_A_RXDATA: rd_data <= rx_reg;
            `SBP_A_STATUS: rd_data <= {bus_free, rx_new_reg, par_err_reg, conn_reg,
                                       tmo_reg, lost_reg, won_reg, state_reg == sbp_pkg::SBP_IDLE};
            `SBP_A_PHASE: rd_data <= {3'h0, bus_in.req, bus_in.msg, bus_in.cd, bus_in.io,
                                      bus_in.bsy};
            default: rd_data <= 8'h00;
         endcase
      end else begin
         rd_data <= 8'h00;
      end
   end

   // i/o rising edge starts data release window
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_prev_reg <= 1'b0;
      end else begin
         io_prev_reg <= bus_in.io;
      end
   end

   // main phase sequencer
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= sbp_pkg::SBP_IDLE;
         cnt_reg <= '0;
         won_reg <= 1'b0;
         lost_reg <= 1'b0;
         tmo_reg <= 1'b0;
         conn_reg <= 1'b0;
      end else if (rst_go) begin
         state_reg <= sbp_pkg::SBP_RESET;
         cnt_reg <= '0;
         conn_reg <= 1'b0;
      end else if (bus_in.rst && state_reg != sbp_pkg::SBP_RESET) begin
         state_reg <= sbp_pkg::SBP_IDLE;
         conn_reg <= 1'b0;
      end else begin
         // sticky flags: a set later in this block wins over the clear
         if (rd_en && addr == `SBP_A_STATUS) begin
            won_reg <= 1'b0;
            lost_reg <= 1'b0;
            tmo_reg <= 1'b0;
         end
         case (state_reg)
            sbp_pkg::SBP_IDLE: begin
               // wait for software to ask for the bus
               cnt_reg <= '0;
               if (arb_go) begin
                  state_reg <= sbp_pkg::SBP_FREE_WAIT;
               end
            end
            sbp_pkg::SBP_FREE_WAIT: begin
               // free delay after free detect, well inside the set limit
               if (!bus_free) begin
                  cnt_reg <= '0;
               end else if (cnt_reg >= `SBP_CNT_W'(FREE_C)) begin
                  state_reg <= sbp_pkg::SBP_ARB;
                  cnt_reg <= '0;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            sbp_pkg::SBP_ARB: begin
               // sel from another device means it has already won
               if (bus_in.sel) begin
                  state_reg <= sbp_pkg::SBP_LOST;
               end else if (cnt_reg >= `SBP_CNT_W'(ARB_C)) begin
                  cnt_reg <= '0;
                  if ((bus_in.db & higher_mask) == 8'h00) begin
                     state_reg <= sbp_pkg::SBP_SEL;
                     won_reg <= 1'b1;
                  end else begin
                     state_reg <= sbp_pkg::SBP_LOST;
                  end
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            sbp_pkg::SBP_LOST: begin
               // lines drop with the state change, well inside the clear delay
               lost_reg <= 1'b1;
               state_reg <= sbp_pkg::SBP_IDLE;
            end
            sbp_pkg::SBP_SEL: begin
               // hold busy plus sel one settle before dropping busy
               if (cnt_reg >= `SBP_CNT_W'(SETTLE_C)) begin
                  state_reg <= sbp_pkg::SBP_SEL_WAIT;
                  cnt_reg <= '0;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            sbp_pkg::SBP_SEL_WAIT: begin
               if (bus_in.bsy && cnt_reg >= `SBP_CNT_W'(SETTLE_C)) begin
                  state_reg <= sbp_pkg::SBP_CONN;
                  conn_reg <= 1'b1;
               // no reply before the timeout: give up the selection
               end else if (cnt_reg >= `SBP_CNT_W'(SEL_TMO_C)) begin
                  state_reg <= sbp_pkg::SBP_IDLE;
                  tmo_reg <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            sbp_pkg::SBP_CONN, sbp_pkg::SBP_ACK_HOLD: begin
               // target dropping busy ends the conversation
               if (!bus_in.bsy || (wr_en && addr == `SBP_A_CTRL && wr_data[`SBP_C_DROP])) begin
                  state_reg <= sbp_pkg::SBP_IDLE;
                  conn_reg <= 1'b0;
               end else if (byte_in) begin
                  state_reg <= sbp_pkg::SBP_ACK_HOLD;
               end else if (state_reg == sbp_pkg::SBP_ACK_HOLD && !bus_in.req) begin
                  state_reg <= sbp_pkg::SBP_CONN;
               end
            end
            sbp_pkg::SBP_RESET: begin
               // full hold time, no upper limit needed
               if (cnt_reg >= `SBP_CNT_W'(RST_C)) begin
                  state_reg <= sbp_pkg::SBP_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            default: state_reg <= sbp_pkg::SBP_IDLE;
         endcase
      end
   end

   // data window after i/o rises: initiator stops driving data
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_rel_reg <= 9'h000;
      end else if (bus_in.io && !io_prev_reg) begin
         io_rel_reg <= 9'(REL_C);
      end else if (io_rel_reg != 9'h000) begin
         io_rel_reg <= io_rel_reg - 9'h001;
      end
   end

   // byte capture with optional odd parity check
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_reg <= 8'h00;
         rx_new_reg <= 1'b0;
         par_err_reg <= 1'b0;
      end else begin
         // clears first so a byte landing in the read cycle still sets
         if (rd_en && addr == `SBP_A_RXDATA) begin
            rx_new_reg <= 1'b0;
         end
         if (rd_en && addr == `SBP_A_STATUS) begin
            par_err_reg <= 1'b0;
         end
         if (byte_in && bus_in.io) begin
            rx_reg <= bus_in.db;
            rx_new_reg <= 1'b1;
            // parity only valid outside arbitration
            if (ctrl_reg[`SBP_C_PAREN] && ~^{bus_in.par, bus_in.db}) begin
               par_err_reg <= 1'b1;
            end
         end
      end
   end

   // line drivers, all straight from flip-flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_out <= '0;
         bus_oe <= '0;
      end else begin
         bus_out <= '0;
         bus_oe <= '0;
         // released lines: enable low is enough, open drain
         case (state_reg)
            sbp_pkg::SBP_ARB: begin
               if (!bus_in.sel) begin
                  bus_oe.bsy <= 1'b1;
                  bus_oe.db <= own_bit;
                  bus_out.bsy <= 1'b1;
                  bus_out.db <= own_bit;
               end
            end
            sbp_pkg::SBP_SEL, sbp_pkg::SBP_SEL_WAIT: begin
               bus_oe.sel <= 1'b1;
               bus_out.sel <= 1'b1;
               bus_oe.bsy <= state_reg == sbp_pkg::SBP_SEL;
               bus_out.bsy <= state_reg == sbp_pkg::SBP_SEL;
               bus_oe.db <= own_bit | (8'h01 << target_reg);
               bus_out.db <= own_bit | (8'h01 << target_reg);
               bus_oe.par <= 1'b1;
               bus_out.par <= ~^(own_bit | (8'h01 << target_reg));
               bus_oe.atn <= ctrl_reg[`SBP_C_ATN];
               bus_out.atn <= ctrl_reg[`SBP_C_ATN];
            end
            sbp_pkg::SBP_CONN, sbp_pkg::SBP_ACK_HOLD: begin
               bus_oe.atn <= ctrl_reg[`SBP_C_ATN];
               bus_out.atn <= ctrl_reg[`SBP_C_ATN];
               bus_oe.ack <= state_reg == sbp_pkg::SBP_ACK_HOLD || byte_in;
               bus_out.ack <= state_reg == sbp_pkg::SBP_ACK_HOLD || byte_in;
               // drive data only while i/o says outbound
               if (!bus_in.io && io_rel_reg == 9'h000) begin
                  bus_oe.db <= tx_reg;
                  bus_out.db <= tx_reg;
                  bus_oe.par <= 1'b1;
                  bus_out.par <= ~^tx_reg;
               end
            end
            sbp_pkg::SBP_RESET: begin
               bus_oe.rst <= 1'b1;
               bus_out.rst <= 1'b1;
            end
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

/* sbp_host_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sbp_host_monitor (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire sbp_pkg::sbp_lines_t bus_in,
   input wire sbp_pkg::sbp_lines_t bus_out,
   input wire sbp_pkg::sbp_lines_t bus_oe
);
   logic [15:0] free_cnt, arb_cnt, rst_cnt;
   logic hbsy, hsel, hrst;
   sbp_pkg::sbp_lines_t h;
   // lines the host itself asserts
   assign h = bus_out & bus_oe;
   assign hbsy = h.bsy;
   assign hsel = h.sel;
   assign hrst = h.rst;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // run lengths; runs stay far below the counter wrap
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         free_cnt <= 16'h0000;
         arb_cnt <= 16'h0000;
         rst_cnt <= 16'h0000;
      end else begin
         free_cnt <= (bus_in.bsy | bus_in.sel) ? 16'h0000 : free_cnt + 16'h0001;
         arb_cnt <= (hbsy & ~hsel) ? arb_cnt + 16'h0001 : 16'h0000;
         rst_cnt <= hrst ? rst_cnt + 16'h0001 : 16'h0000;
      end
   end
   property p_free_wait;
      $rose(hbsy) && !hsel |-> free_cnt >= 16'h0096;
   endproperty
   a_free_wait: assert property (p_free_wait) else $error("arbitration too soon");
   property p_id_bsy;
      $rose(hbsy) && !hsel |-> (|h.db);
   endproperty
   a_id_bsy: assert property (p_id_bsy) else $error("no id with busy");
   property p_arb_wait;
      $rose(hsel) && hbsy |-> arb_cnt >= 16'h0113;
   endproperty
   a_arb_wait: assert property (p_arb_wait) else $error("arbitration judged early");
   property p_par;
      hsel && bus_oe.par |-> bus_out.par == ~(^bus_out.db);
   endproperty
   a_par: assert property (p_par) else $error("even parity driven");
   property p_rst_hold;
      $fell(hrst) |-> rst_cnt >= 16'h0C35;
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("reset too short");
   property p_rst_clear;
      $rose(bus_in.rst) |-> ##[0:100] !(hbsy | hsel | (|bus_oe.db));
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("bus not cleared");
   property p_data_rel;
      $rose(bus_in.io) |-> ##[0:50] !(|bus_oe.db);
   endproperty
   a_data_rel: assert property (p_data_rel) else $error("data not released");
   property p_ack;
      $rose(h.ack) |-> bus_in.req;
   endproperty
   a_ack: assert property (p_ack) else $error("ack without req");
   c_sel: cover property ($rose(hsel));
   c_ack: cover property ($rose(h.ack));
   c_rst: cover property ($fell(hrst));
endmodule
bind sbp_host sbp_host_monitor u_sbp_host_monitor (
   .core_clk(core_clk),
   .reset_n(reset_n),
   .bus_in(bus_in),
   .bus_out(bus_out),
   .bus_oe(bus_oe)
);
`default_nettype wire

/* sbp_target.sv */
`timescale 1ns/1ps
`default_nettype none
module sbp_target (
   input wire logic core_clk,
   input wire sbp_pkg::sbp_lines_t bus_in,
   input wire logic [2:0] my_id,
   input wire logic [7:0] tx_byte,
   input wire logic bad_par,
   output sbp_pkg::sbp_lines_t t_out
);
   // answers a selection with one inbound data byte, then frees the bus
   initial begin
      t_out = '0;
      forever begin
         @(posedge core_clk);
         // bus reset: the drive drops everything and comes back at bus free
         if (bus_in.rst) begin
            t_out <= '0;
         end else if (bus_in.sel && !bus_in.bsy && bus_in.db[my_id]) begin
            repeat (20) @(posedge core_clk);
            t_out.bsy <= 1'b1;
            while (bus_in.sel) @(posedge core_clk);
            t_out.cd <= 1'b0;
            t_out.io <= 1'b1;
            t_out.db <= tx_byte;
            t_out.par <= ~(^tx_byte) ^ bad_par;
            repeat (60) @(posedge core_clk);
            t_out.req <= 1'b1;
            while (!bus_in.ack) @(posedge core_clk);
            t_out.req <= 1'b0;
            while (bus_in.ack) @(posedge core_clk);
            t_out <= '0;
         end
      end
   end
endmodule
`default_nettype wire

/* scsi_bus_phase_timing_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module scsi_bus_phase_timing_port_tb;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] tx_byte = 8'h00;
   logic [7:0] rd_data, v;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic bad_par = 1'b0;
   logic atn_at_req = 1'b0;
   logic [7:0] rival_db = 8'h00;
   logic [2:0] tgt_id = 3'h0;
   logic [31:0] seed = 32'hE78CB1E6;
   sbp_pkg::sbp_lines_t bus_in, bus_out, bus_oe, t_out;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int k;
   logic [7:0] exp_q[$];
   always #4 core_clk = ~core_clk;
   // wired-or of every party; released lines read deasserted
   // rival_db stands in for a higher device arbitrating against us
   assign bus_in = sbp_pkg::sbp_lines_t'((bus_out & bus_oe) | t_out | 18'(rival_db));
   sbp_host #(.SEL_TMO_C(2000)) u_sbp_host (.core_clk(core_clk), .reset_n(reset_n),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe));
   sbp_target u_sbp_target (.core_clk(core_clk), .bus_in(bus_in), .my_id(tgt_id),
      .tx_byte(tx_byte), .bad_par(bad_par), .t_out(t_out));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] r;
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1 v = rd_data;
   endtask
   task automatic poll(input int b);
      k = 0;
      do begin
         rd(4'h4);
         k++;
      end while (v[b] !== 1'b1 && k < 3000);
   endtask
   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         stop_test();
      end
   end
   // atn level seen while the target asks for a byte
   always @(posedge core_clk) begin
      if (bus_in.req) begin
         atn_at_req <= bus_in.atn;
      end
   end
   initial begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (60) @(posedge core_clk);
      rd(4'h0);
      chk("ctrl", 8'h80, v);
      rd(4'h5);
      chk("phase", 8'h00, v);
      rd(4'hF);
      chk("unmapped", 8'h00, v);
      rd(4'h4);
      chk("bus_free", 8'h80, v & 8'h80);
      // second pass raises atn; last pass turns parity checking off with a bad byte
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         tgt_id <= seed[2:0] % 3'h7;
         tx_byte <= seed[15:8];
         bad_par <= i[1];
         exp_q.push_back(seed[15:8]);
         wr(4'h1, {5'h00, seed[2:0] % 3'h7});
         wr(4'h2, seed[23:16]);
         wr(4'h0, (i == 3) ? 8'h71 : ((i == 1) ? 8'hF5 : 8'hF1));
         poll(1);
         chk("won", 8'h02, v & 8'h02);
         poll(6);
         chk("par_err", {7'h00, i[1] & (i != 3)}, {7'h00, v[5]});
         chk("atn", {7'h00, i == 1}, {7'h00, atn_at_req});
         rd(4'h3);
         chk("rx_byte", exp_q.pop_front(), v);
         poll(7);
      end
      tgt_id <= 3'h0;
      wr(4'h1, 8'h05);
      wr(4'h0, 8'hF1);
      repeat (1500) @(posedge core_clk);
      rd(4'h4);
      chk("early_tmo", 8'h00, v & 8'h08);
      poll(3);
      chk("timeout", 8'h08, v & 8'h08);
      poll(7);
      // own id 3 against a rival holding data bit 7
      rival_db <= 8'h80;
      wr(4'h0, 8'hB1);
      poll(2);
      chk("lost", 8'h04, v & 8'h06);
      rival_db <= 8'h00;
      poll(7);
      wr(4'h0, 8'hF2);
      k = 0;
      while (bus_in.rst !== 1'b1 && k < 100) begin
         @(posedge core_clk);
         k++;
      end
      k = 0;
      while (bus_in.rst === 1'b1 && k < 10000) begin
         @(posedge core_clk);
         k++;
      end
      chk("rst_hold", 8'h01, {7'h00, k >= 3125});
      poll(7);
      chk("free_after_rst", 8'h81, v & 8'h81);
      stop_test();
   end
endmodule
`default_nettype wire
